// file: snv_pkg.sv
// Register map, field positions, reset values and timing constants.
package snv_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 100;
  localparam int unsigned RESTORE_DELAY_US   = 1000;
  localparam int unsigned PROGRAM_TIME_US    = 500;
  localparam int unsigned RESTORE_CYCLES     =
    (RESTORE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROGRAM_CYCLES     =
    (PROGRAM_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W            = 16;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W             = 7;
  localparam logic [6:0]  ADDR_SYS_CAP_EN    = 7'h04;
  localparam logic [6:0]  ADDR_SUP_CAP_EN    = 7'h1C;
  localparam logic [6:0]  ADDR_TRX_CAP_EN    = 7'h23;
  localparam logic [6:0]  ADDR_SUP_FLAGS     = 7'h62;
  localparam logic [6:0]  ADDR_TRX_FLAGS     = 7'h63;
  localparam logic [6:0]  ADDR_NV_STATUS     = 7'h70;
  localparam logic [6:0]  ADDR_NV_STARTUP    = 7'h73;
  localparam logic [6:0]  ADDR_NV_CONFIG     = 7'h74;
  localparam logic [6:0]  ADDR_NV_CHECKSUM   = 7'h75;
  localparam logic [6:0]  ADDR_IDENTITY      = 7'h7E;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_OVERTEMP_EN    = 2;
  localparam int unsigned BIT_SERIAL_EN      = 1;
  localparam int unsigned BIT_UNDERVOLT      = 0;
  localparam int unsigned BIT_SILENCE        = 4;
  localparam int unsigned BIT_FAILURE        = 1;
  localparam int unsigned BIT_WAKEUP         = 0;
  localparam int unsigned BIT_FORCED_CFG     = 3;
  localparam int unsigned BIT_PROG_ERROR     = 1;
  localparam int unsigned BIT_PROG_READY     = 0;
  localparam int unsigned CNT_LSB            = 2;
  localparam int unsigned CNT_W              = 6;
  localparam logic [7:0]  SYS_CAP_MASK       = 8'h06;
  localparam logic [7:0]  SUP_MASK           = 8'h01;
  localparam logic [7:0]  TRX_MASK           = 8'h13;
  localparam logic [7:0]  CAP_EN_RESET       = 8'h00;
  localparam logic [7:0]  FLAGS_RESET        = 8'h00;
  localparam logic [5:0]  CNT_RESET          = 6'h00;
  localparam logic [5:0]  CNT_MAX            = 6'h3F;
  localparam logic [7:0]  FACTORY_STARTUP    = 8'h00;
  localparam logic [7:0]  FACTORY_CONFIG     = 8'h08;
  localparam logic [7:0]  IDENTITY_DEFAULT   = 8'h5A;

  // ----------------------------------------------------------------
  // Checksum
  // ----------------------------------------------------------------
  localparam logic [7:0]  CRC_POLY           = 8'h2F;
  localparam logic [7:0]  CRC_INIT           = 8'hFF;
  localparam logic [7:0]  CRC_XOROUT         = 8'hFF;

  // ----------------------------------------------------------------
  // Synchronised pin inputs
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W             = 9;
  localparam int unsigned IN_UNDERVOLT       = 0;
  localparam int unsigned IN_SILENCE         = 1;
  localparam int unsigned IN_FAILURE         = 2;
  localparam int unsigned IN_WAKEUP          = 3;
  localparam int unsigned IN_OFFLINE         = 4;
  localparam int unsigned IN_RESET_OUT_PIN_LOW        = 5;
  localparam int unsigned IN_CANH_HIGH       = 6;
  localparam int unsigned IN_CANL_LOW        = 7;
  localparam int unsigned IN_POWER_UP        = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_PROGRAM, ST_RESTORE} snv_state_t;

endpackage : snv_pkg

// file: snv_nv_config.sv
// Event flags, capture enables and reprogrammable configuration store.
// ------------------------------------------------------------------
// Functional notes
// - Supply flag bit0 captures undervoltage, sticky
// - Transceiver flags: silence 4, failure 1, wake 0
// - Wake flag set only while transceiver offline
// - System enables: overtemp bit2, serial bit1
// - Supply enable at 1Ch, undervoltage bit0
// - Transceiver enables at 23h: bits 4,1,0
// - Configuration cells at 73h and 74h
// - Program only in forced mode, factory state
// - Forced mode follows stored forced-mode bit
// - Checksum write at 75h starts, mismatch aborts
// - Successful programming issues system reset
// - Cells read zero while programming
// - Successful programming locks further cell writes
// - Six-bit counter at 70h, saturating
// - Status: error bit1, ready bit0
// - CRC8 poly 2Fh, init FFh, inverted
// - CRC over 73h then 74h, MSB first
// - Pin pattern at power-up restores presets
// - Receive output held high during restore
// - Identity byte at 7Eh read-only
// - Lock blocks serial writes, not hardware updates
// - Write one clears flag, zero keeps
// - Flag set only while capture enabled
// ------------------------------------------------------------------
`timescale 1ns/1ns

module snv_nv_config #(
  parameter int unsigned RESTORE_CYC     = snv_pkg::RESTORE_CYCLES,
  parameter int unsigned PROGRAM_CYC     = snv_pkg::PROGRAM_CYCLES,
  parameter logic [7:0]  FACTORY_STARTUP = snv_pkg::FACTORY_STARTUP,
  parameter logic [7:0]  FACTORY_CONFIG  = snv_pkg::FACTORY_CONFIG,
  // Identity value is arbitrary.
  parameter logic [7:0]  IDENTITY_CODE   = snv_pkg::IDENTITY_DEFAULT
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  // Register access from the serial frame logic
  input  wire logic                         regWrStb,
  input  wire logic                         regRdStb,
  input  wire logic [snv_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [7:0]                   regWrData,
  output logic      [7:0]                   regRdData,
  // Context from neighbouring logic
  input  wire logic                         forcedDefaultMode,
  input  wire logic                         lockRegulatorArea,
  input  wire logic                         lockTransceiverArea,
  input  wire logic                         cellWriteFault,
  // Analog event and pin inputs
  input  wire logic                         regulatorUndervolt,
  input  wire logic                         busSilence,
  input  wire logic                         transceiverFailure,
  input  wire logic                         busWakeup,
  input  wire logic                         transceiverOffline,
  input  wire logic                         resetOutPinLow,
  input  wire logic                         canhAtBattery,
  input  wire logic                         canlAtGround,
  input  wire logic                         powerUpPhase,
  // Configuration and control outputs
  output logic                              overtempWarnCaptureEn,
  output logic                              serialFailureCaptureEn,
  output logic                              forcedDefaultModeCfg,
  output logic      [7:0]                   startupCfg,
  output logic      [7:0]                   deviceCfg,
  output logic                              systemResetReq,
  output logic                              receiveDataForceHigh,
  output logic                              programBusy
);
  import snv_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic              rstA_ff;
  logic              reset_out_pin;
  logic [SYNC_W-1:0] syncA_ff;
  logic [SYNC_W-1:0] syncB_ff;
  logic [SYNC_W-1:0] rawIn;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstA_ff <= 1'b0;
      reset_out_pin    <= 1'b0;
    end
    else
    begin
      rstA_ff <= 1'b1;
      reset_out_pin    <= rstA_ff;
    end
  end

  assign rawIn = {powerUpPhase, canlAtGround, canhAtBattery, resetOutPinLow,
                  transceiverOffline, busWakeup, transceiverFailure,
                  busSilence, regulatorUndervolt};

  always_ff @(posedge ref_clk or negedge reset_out_pin)
  begin
    if (!reset_out_pin)
    begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end
    else
    begin
      syncA_ff <= rawIn;
      syncB_ff <= syncA_ff;
    end
  end

  // ----------------------------------------------------------------
  // Checksum over the two staged bytes
  // ----------------------------------------------------------------
  function automatic logic [7:0] snv_crc8(input logic [7:0] b0,
                                          input logic [7:0] b1);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 2; i++)
    begin
      c = c ^ ((i == 0) ? b0 : b1);
      for (int j = 0; j < 8; j++)
        c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c ^ CRC_XOROUT;
  endfunction : snv_crc8

  // ----------------------------------------------------------------
  // State and register storage
  // ----------------------------------------------------------------
  snv_state_t         state_ff;
  snv_state_t         nxt_state;
  logic [TIMER_W-1:0] timer_ff;
  logic [TIMER_W-1:0] nxt_timer;
  logic [7:0]         sysCapEn_ff;
  logic [7:0]         supCapEn_ff;
  logic [7:0]         trxCapEn_ff;
  logic [7:0]         supFlags_ff;
  logic [7:0]         trxFlags_ff;
  logic [7:0]         cellStartup_ff;
  logic [7:0]         cellConfig_ff;
  logic [7:0]         stageStartup_ff;
  logic [7:0]         stageConfig_ff;
  logic [7:0]         checksum_ff;
  logic [CNT_W-1:0]   writeCount_ff;
  logic               progError_ff;
  logic               progReady_ff;
  logic               restoreDone_ff;
  logic [7:0]         nxt_rdData;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire idle       = (state_ff == ST_IDLE);
  wire nvWriteOk  = idle && forcedDefaultMode && progReady_ff;
  wire wrSysCap   = regWrStb && (regAddr == ADDR_SYS_CAP_EN);
  wire wrSupCap   = regWrStb && (regAddr == ADDR_SUP_CAP_EN)
                    && !lockRegulatorArea;
  wire wrTrxCap   = regWrStb && (regAddr == ADDR_TRX_CAP_EN)
                    && !lockTransceiverArea;
  wire wrSupFlags = regWrStb && (regAddr == ADDR_SUP_FLAGS);
  wire wrTrxFlags = regWrStb && (regAddr == ADDR_TRX_FLAGS);
  wire wrStartup  = regWrStb && (regAddr == ADDR_NV_STARTUP) && nvWriteOk;
  wire wrConfig   = regWrStb && (regAddr == ADDR_NV_CONFIG) && nvWriteOk;
  wire wrChecksum = regWrStb && (regAddr == ADDR_NV_CHECKSUM) && nvWriteOk;
  wire crcMatch   = (regWrData == snv_crc8(stageStartup_ff, stageConfig_ff));
  wire progStart  = wrChecksum && crcMatch;

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  // The set term is ORed in after the clear so a coincident event wins.
  wire [7:0] supSet = {7'h00, syncB_ff[IN_UNDERVOLT]
                       & supCapEn_ff[BIT_UNDERVOLT]};
  wire [7:0] trxSet = {3'h0, syncB_ff[IN_SILENCE] & trxCapEn_ff[BIT_SILENCE],
                       2'h0, syncB_ff[IN_FAILURE] & trxCapEn_ff[BIT_FAILURE],
                       syncB_ff[IN_WAKEUP] & syncB_ff[IN_OFFLINE]
                       & trxCapEn_ff[BIT_WAKEUP]};
  wire [7:0] supClr = wrSupFlags ? (regWrData & SUP_MASK) : 8'h00;
  wire [7:0] trxClr = wrTrxFlags ? (regWrData & TRX_MASK) : 8'h00;
  wire [7:0] nxt_supFlags = (supFlags_ff & ~supClr) | supSet;
  wire [7:0] nxt_trxFlags = (trxFlags_ff & ~trxClr) | trxSet;

  // ----------------------------------------------------------------
  // Sequencer for programming and preset restore
  // ----------------------------------------------------------------
  wire restoreCond = syncB_ff[IN_POWER_UP] && syncB_ff[IN_RESET_OUT_PIN_LOW]
                     && syncB_ff[IN_CANH_HIGH] && syncB_ff[IN_CANL_LOW]
                     && !restoreDone_ff;
  wire timerEnd    = (state_ff == ST_PROGRAM)
                     ? (timer_ff == TIMER_W'(PROGRAM_CYC - 1))
                     : (timer_ff == TIMER_W'(RESTORE_CYC - 1));
  wire progDone    = (state_ff == ST_PROGRAM) && timerEnd;
  wire restoreGo   = idle && restoreCond && timerEnd;
  wire restoreEnd  = (state_ff == ST_RESTORE)
                     && (timer_ff == TIMER_W'(PROGRAM_CYC - 1));
  wire progOk      = progDone && !cellWriteFault;
  wire [CNT_W-1:0] cntInc = (writeCount_ff == CNT_MAX) ? CNT_MAX
                            : writeCount_ff + 1'b1;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_timer = timer_ff + 1'b1;
    case (state_ff)
      ST_IDLE:
      begin
        if (progStart)
        begin
          nxt_state = ST_PROGRAM;
          nxt_timer = '0;
        end
        else if (restoreGo)
        begin
          nxt_state = ST_RESTORE;
          nxt_timer = '0;
        end
        else if (!restoreCond)
          nxt_timer = '0;
      end
      ST_PROGRAM:
      begin
        if (progDone)
        begin
          nxt_state = ST_IDLE;
          nxt_timer = '0;
        end
      end
      ST_RESTORE:
      begin
        if (restoreEnd)
        begin
          nxt_state = ST_IDLE;
          nxt_timer = '0;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_timer = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Cell bytes read zero while the store is busy; the array is not
  // readable during a write cycle.
  always_comb
  begin
    case (regAddr)
      ADDR_SYS_CAP_EN:  nxt_rdData = sysCapEn_ff;
      ADDR_SUP_CAP_EN:  nxt_rdData = supCapEn_ff;
      ADDR_TRX_CAP_EN:  nxt_rdData = trxCapEn_ff;
      ADDR_SUP_FLAGS:   nxt_rdData = supFlags_ff;
      ADDR_TRX_FLAGS:   nxt_rdData = trxFlags_ff;
      ADDR_NV_STATUS:   nxt_rdData = {writeCount_ff, progError_ff,
                                      progReady_ff};
      ADDR_NV_STARTUP:  nxt_rdData = idle ? stageStartup_ff : 8'h00;
      ADDR_NV_CONFIG:   nxt_rdData = idle ? stageConfig_ff : 8'h00;
      ADDR_NV_CHECKSUM: nxt_rdData = checksum_ff;
      ADDR_IDENTITY:    nxt_rdData = IDENTITY_CODE;
      default:          nxt_rdData = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_out_pin)
  begin
    if (!reset_out_pin)
    begin
      state_ff    <= ST_IDLE;
      timer_ff    <= '0;
      regRdData   <= 8'h00;
      sysCapEn_ff <= CAP_EN_RESET;
      supCapEn_ff <= CAP_EN_RESET;
      trxCapEn_ff <= CAP_EN_RESET;
      supFlags_ff <= FLAGS_RESET;
      trxFlags_ff <= FLAGS_RESET;
      checksum_ff <= 8'h00;
    end
    else
    begin
      state_ff    <= nxt_state;
      timer_ff    <= nxt_timer;
      regRdData   <= regRdStb ? nxt_rdData : regRdData;
      sysCapEn_ff <= wrSysCap ? (regWrData & SYS_CAP_MASK) : sysCapEn_ff;
      supCapEn_ff <= wrSupCap ? (regWrData & SUP_MASK) : supCapEn_ff;
      trxCapEn_ff <= wrTrxCap ? (regWrData & TRX_MASK) : trxCapEn_ff;
      supFlags_ff <= nxt_supFlags;
      trxFlags_ff <= nxt_trxFlags;
      checksum_ff <= wrChecksum ? regWrData : checksum_ff;
    end
  end

  // Cell contents only change at the end of a program or restore cycle; a cell fault leaves
  // the old values and reports the error instead.
  always_ff @(posedge ref_clk or negedge reset_out_pin)
  begin
    if (!reset_out_pin)
    begin
      cellStartup_ff  <= FACTORY_STARTUP;
      cellConfig_ff   <= FACTORY_CONFIG;
      stageStartup_ff <= FACTORY_STARTUP;
      stageConfig_ff  <= FACTORY_CONFIG;
      writeCount_ff   <= CNT_RESET;
      progError_ff    <= 1'b0;
      progReady_ff    <= 1'b1;
      restoreDone_ff  <= 1'b0;
    end
    else if (progDone)
    begin
      cellStartup_ff <= progOk ? stageStartup_ff : cellStartup_ff;
      cellConfig_ff  <= progOk ? stageConfig_ff : cellConfig_ff;
      writeCount_ff  <= cntInc;
      progError_ff   <= cellWriteFault;
      progReady_ff   <= !progOk;
    end
    else if (restoreEnd)
    begin
      cellStartup_ff  <= FACTORY_STARTUP;
      cellConfig_ff   <= FACTORY_CONFIG;
      stageStartup_ff <= FACTORY_STARTUP;
      stageConfig_ff  <= FACTORY_CONFIG;
      writeCount_ff   <= cntInc;
      progError_ff    <= 1'b0;
      progReady_ff    <= 1'b1;
      restoreDone_ff  <= 1'b1;
    end
    else
    begin
      stageStartup_ff <= wrStartup ? regWrData : stageStartup_ff;
      stageConfig_ff  <= wrConfig ? regWrData : stageConfig_ff;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_out_pin)
  begin
    if (!reset_out_pin)
    begin
      overtempWarnCaptureEn  <= 1'b0;
      serialFailureCaptureEn <= 1'b0;
      forcedDefaultModeCfg   <= FACTORY_CONFIG[BIT_FORCED_CFG];
      startupCfg             <= FACTORY_STARTUP;
      deviceCfg              <= FACTORY_CONFIG;
      systemResetReq         <= 1'b0;
      receiveDataForceHigh   <= 1'b0;
      programBusy            <= 1'b0;
    end
    else
    begin
      overtempWarnCaptureEn  <= sysCapEn_ff[BIT_OVERTEMP_EN];
      serialFailureCaptureEn <= sysCapEn_ff[BIT_SERIAL_EN];
      forcedDefaultModeCfg   <= cellConfig_ff[BIT_FORCED_CFG];
      startupCfg             <= cellStartup_ff;
      deviceCfg              <= cellConfig_ff;
      systemResetReq         <= progOk || restoreEnd;
      receiveDataForceHigh   <= (nxt_state == ST_RESTORE);
      programBusy            <= (nxt_state == ST_PROGRAM);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_out_pin);

  property p_undervoltCapture;
    syncB_ff[IN_UNDERVOLT] && supCapEn_ff[BIT_UNDERVOLT]
      |=> supFlags_ff[BIT_UNDERVOLT]
          ##1 (supFlags_ff[BIT_UNDERVOLT] || $past(supClr[BIT_UNDERVOLT]));
  endproperty
  a_undervoltCapture: assert property (p_undervoltCapture)
    else $error("Undervoltage flag not captured");

  property p_wakeOffline;
    $rose(trxFlags_ff[BIT_WAKEUP]) |-> $past(syncB_ff[IN_OFFLINE]);
  endproperty
  a_wakeOffline: assert property (p_wakeOffline)
    else $error("Wake flag set while not offline");

  property p_flagClear;
    wrTrxFlags && regWrData[BIT_FAILURE] && !trxSet[BIT_FAILURE]
      |=> !trxFlags_ff[BIT_FAILURE];
  endproperty
  a_flagClear: assert property (p_flagClear)
    else $error("Failure flag not cleared by write of one");

  property p_badCrcAbort;
    wrChecksum && !crcMatch |=> idle [*3];
  endproperty
  a_badCrcAbort: assert property (p_badCrcAbort)
    else $error("Programming started on wrong checksum");

  property p_busyReadZero;
    !idle && regRdStb
      && (regAddr == ADDR_NV_CONFIG || regAddr == ADDR_NV_STARTUP)
      |=> regRdData == 8'h00;
  endproperty
  a_busyReadZero: assert property (p_busyReadZero)
    else $error("Cell byte returned during programming");

  property p_resetOnSuccess;
    progDone && !cellWriteFault |=> systemResetReq ##1 !systemResetReq;
  endproperty
  a_resetOnSuccess: assert property (p_resetOnSuccess)
    else $error("No single reset pulse after programming");

  property p_lockedAfterProg;
    !progReady_ff && regWrStb && (regAddr == ADDR_NV_STARTUP)
      |=> $stable(stageStartup_ff);
  endproperty
  a_lockedAfterProg: assert property (p_lockedAfterProg)
    else $error("Cell byte written after programming");

  property p_counterSaturates;
    (writeCount_ff == CNT_MAX) |=> (writeCount_ff == CNT_MAX);
  endproperty
  a_counterSaturates: assert property (p_counterSaturates)
    else $error("Write counter wrapped");

  property p_counterStep;
    (progDone || restoreEnd) && (writeCount_ff != CNT_MAX)
      |=> writeCount_ff == CNT_W'($past(writeCount_ff) + 1'b1);
  endproperty
  a_counterStep: assert property (p_counterStep)
    else $error("Write counter did not step by one");

  property p_lockedEnable;
    regWrStb && (regAddr == ADDR_SUP_CAP_EN) && lockRegulatorArea
      |=> $stable(supCapEn_ff);
  endproperty
  a_lockedEnable: assert property (p_lockedEnable)
    else $error("Locked enable register changed");

  property p_rxdRestore;
    (state_ff == ST_RESTORE) |-> receiveDataForceHigh;
  endproperty
  a_rxdRestore: assert property (p_rxdRestore)
    else $error("Receive output not high during restore");

  c_program: cover property (progStart ##[1:20] systemResetReq);
  c_restore: cover property (restoreGo ##[1:20] systemResetReq);
  c_setClear: cover property (wrTrxFlags && (trxSet != 8'h00));

endmodule : snv_nv_config

// file: snv_host_model.sv
// Host model issuing single-byte register accesses.
`timescale 1ns/1ns
module snv_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Register strobes
  output logic            regWrStb,
  output logic            regRdStb,
  output logic [6:0]      regAddr,
  output logic [7:0]      regWrData
);
  logic [7:0] expQ[$];
  initial
  begin
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    regAddr = 7'h00;
    regWrData = 8'h00;
  end
  // Strobes change at the falling edge and last one clock.
  task automatic acc(input logic w, input logic [6:0] a,
                     input logic [7:0] d);
    @(negedge ref_clk);
    regWrStb = w;
    regRdStb = !w;
    regAddr = a;
    regWrData = d;
    @(negedge ref_clk);
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  endtask : acc
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    expQ.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : rd
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h2F : 8'h00);
    return ~c;
  endfunction : crc8
  // Caller holds forced mode and stays far below the program limit.
  task automatic prog(input logic [7:0] s, input logic [7:0] c,
                      input logic ok);
    acc(1'b1, 7'h73, s);
    acc(1'b1, 7'h74, c);
    acc(1'b1, 7'h75, ok ? crc8({s, c}) : ~crc8({s, c}));
  endtask : prog
endmodule : snv_host_model

// file: snv_nv_config_tb.sv
// Self-checking bench for the event and configuration register block.
`timescale 1ns/1ns
module snv_nv_config_tb;
  import snv_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  ctl = 4'h0;
  logic [8:0]  pin = 9'h000;
  logic        wStb, rStb, otw, sfe, fCfg, rxHi, sysRst, busy;
  logic [6:0]  addr;
  logic [7:0]  wDat, rDat, sCfg, dCfg;
  logic [31:0] rng = 32'hC875D9F1;
  logic        rdSeen = 1'b0;
  logic [6:0]  ca [3] = '{7'h04, 7'h1C, 7'h23};
  logic [7:0]  cm [3] = '{8'h06, 8'h01, 8'h13};
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  wire  [1:0]  hi = {rxHi, sysRst};
  initial
  begin
    forever #50 ref_clk = !ref_clk;
  end
  snv_nv_config #(.RESTORE_CYC(8), .PROGRAM_CYC(5)) snv_nv_config_i (
    .ref_clk(ref_clk), .resetn(resetn), .regWrStb(wStb), .regRdStb(rStb),
    .regAddr(addr), .regWrData(wDat), .regRdData(rDat),
    .forcedDefaultMode(ctl[0]), .lockRegulatorArea(ctl[1]),
    .lockTransceiverArea(ctl[2]), .cellWriteFault(ctl[3]),
    .regulatorUndervolt(pin[0]), .busSilence(pin[1]),
    .transceiverFailure(pin[2]), .busWakeup(pin[3]),
    .transceiverOffline(pin[4]), .resetOutPinLow(pin[5]),
    .canhAtBattery(pin[6]), .canlAtGround(pin[7]), .powerUpPhase(pin[8]),
    .overtempWarnCaptureEn(otw), .serialFailureCaptureEn(sfe),
    .forcedDefaultModeCfg(fCfg), .startupCfg(sCfg), .deviceCfg(dCfg),
    .systemResetReq(sysRst), .receiveDataForceHigh(rxHi),
    .programBusy(busy));
  snv_host_model snv_host_model_i (.ref_clk(ref_clk), .regWrStb(wStb),
    .regRdStb(rStb), .regAddr(addr), .regWrData(wDat));
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  function automatic void rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
  endfunction : rnd
  // Every wait is bounded; running out is a mismatch and ends the run.
  task automatic wait_hi(input int k);
    for (n = 0; n < 40 && hi[k] !== 1'b1; n++)
      @(negedge ref_clk);
    if (n == 40)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask : wait_hi
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    snv_host_model_i.acc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    snv_host_model_i.rd(a, e);
  endtask : rd
  // Events are held long enough to pass the input synchronisers.
  task automatic evt(input logic [4:0] v);
    @(negedge ref_clk);
    pin[4:0] = v;
    repeat (6) @(negedge ref_clk);
    pin[3:0] = 4'h0;
  endtask : evt
  always @(posedge ref_clk) rdSeen <= rStb;
  always @(negedge ref_clk)
  begin
    if (rdSeen)
      check("read data", rDat, snv_host_model_i.expQ.pop_front());
  end
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(ADDR_NV_STATUS, 8'h01);
    rd(ADDR_IDENTITY, IDENTITY_DEFAULT);
    rd(ADDR_NV_CONFIG, FACTORY_CONFIG);
    rd(7'h10, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      rnd();
      wr(ca[i], rng[7:0]);
      rd(ca[i], rng[7:0] & cm[i]);
      if (i == 0)
      begin
        check("overtemp en", {7'h00, otw}, {7'h00, rng[2]});
        check("serial en", {7'h00, sfe}, {7'h00, rng[1]});
      end
    end
    wr(ADDR_SUP_CAP_EN, 8'h01);
    wr(ADDR_TRX_CAP_EN, 8'h13);
    evt(5'h0F);
    rd(ADDR_SUP_FLAGS, 8'h01);
    rd(ADDR_TRX_FLAGS, 8'h12);
    wr(ADDR_TRX_FLAGS, 8'h02);
    rd(ADDR_TRX_FLAGS, 8'h10);
    evt(5'h18);
    rd(ADDR_TRX_FLAGS, 8'h11);
    ctl[2:1] = 2'b11;
    wr(ADDR_SUP_CAP_EN, 8'h00);
    rd(ADDR_SUP_CAP_EN, 8'h01);
    wr(ADDR_TRX_CAP_EN, 8'h00);
    rd(ADDR_TRX_CAP_EN, 8'h13);
    ctl[2:1] = 2'b00;
    wr(ADDR_SUP_CAP_EN, 8'h00);
    wr(ADDR_SUP_FLAGS, 8'hFF);
    evt(5'h01);
    rd(ADDR_SUP_FLAGS, 8'h00);
    ctl[0] = 1'b1;
    rnd();
    snv_host_model_i.prog(rng[7:0], rng[15:8], 1'b0);
    repeat (3) @(negedge ref_clk);
    check("busy", {7'h00, busy}, 8'h00);
    snv_host_model_i.prog(rng[7:0], rng[15:8], 1'b1);
    check("busy", {7'h00, busy}, 8'h01);
    rd(ADDR_NV_STARTUP, 8'h00);
    wait_hi(0);
    @(negedge ref_clk);
    check("startup", sCfg, rng[7:0]);
    check("config", dCfg, rng[15:8]);
    check("forced", {7'h00, fCfg}, {7'h00, rng[11]});
    rd(ADDR_NV_STATUS, 8'h04);
    wr(ADDR_NV_STARTUP, ~rng[7:0]);
    rd(ADDR_NV_STARTUP, rng[7:0]);
    pin[8:5] = 4'hF;
    wait_hi(1);
    wait_hi(0);
    pin[8:5] = 4'h0;
    @(negedge ref_clk);
    check("restored startup", sCfg, FACTORY_STARTUP);
    check("restored config", dCfg, FACTORY_CONFIG);
    check("forced", {7'h00, fCfg}, {7'h00, FACTORY_CONFIG[3]});
    rd(ADDR_NV_STATUS, 8'h09);
    ctl[3] = 1'b1;
    rnd();
    snv_host_model_i.prog(rng[7:0], rng[15:8], 1'b1);
    repeat (8)
      @(negedge ref_clk) check("no reset", {7'h00, sysRst}, 8'h00);
    check("config kept", dCfg, FACTORY_CONFIG);
    rd(ADDR_NV_STATUS, 8'h0F);
    finish_test();
  end
endmodule : snv_nv_config_tb
